/* src/cycle_timer.sv */
// Down-counting timer, one-shot or periodic, with a one-cycle done pulse.
// Assumes start, clear and hold are synchronous to clk.
`timescale 1ns/100ps
module cycle_timer #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic clear,
  input wire logic hold,
  input wire logic periodic,
  input wire logic [W-1:0] len,
  output logic done_r,
  output logic busy_r
);
  logic [W-1:0] cnt_r;

  if (W < 2) begin : g_chk
    $error("cycle_timer needs W of at least 2");
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (clear) begin
        cnt_r <= '0;
        busy_r <= 1'b0;
      end else if (start && len != '0) begin
        cnt_r <= len;
        busy_r <= 1'b1;
      end else if (busy_r && !hold) begin
        if (cnt_r == {{(W-1){1'b0}}, 1'b1}) begin
          done_r <= 1'b1;
          cnt_r <= len;
          busy_r <= periodic && len != '0;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end
  end

  a_timer_expiry: assert property (@(posedge clk) disable iff (!rst_n)
    busy_r && !hold && !clear && !start && cnt_r == 1 |=> done_r)
    else $error("timer did not expire on its last count");
endmodule // cycle_timer

/* src/pmc_params.svh */
// Constants of the power mode controller: offsets, fields, resets, timing.
// Assumes a 50 MHz system clock and an AXI4-Lite register port.
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PMC_AXI_AW 8
`define PMC_OFF_MODE 8'h00
`define PMC_OFF_ACT_TMPL 8'h04
`define PMC_OFF_ALT_TMPL 8'h08
`define PMC_OFF_WAKE_EN 8'h0c
`define PMC_OFF_CTW_PERIOD 8'h10
`define PMC_OFF_INT_STAT 8'h14
`define PMC_OFF_INT_MASK 8'h18
`define PMC_RESP_OKAY 2'b00
`define PMC_RESP_SLVERR 2'b10

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define PMC_MODE_BUSY_BIT 2
`define PMC_MODE_LAST_LSB 8
`define PMC_NRES 8
`define PMC_RES_CPU 0
`define PMC_SLEEP_KEEP 32'h0000_0006
`define PMC_ACT_TMPL_RST 32'h0000_00ff
`define PMC_ALT_TMPL_RST 32'h0000_00fe
`define PMC_NWAKE 7
`define PMC_WK_CTW 4
`define PMC_WAKE_EN_RST 7'h7f
`define PMC_SLEEP_WAKE_MASK 7'h3f
`define PMC_HIB_WAKE_MASK 7'h02
`define PMC_CTW_W 16
`define PMC_NINT 4
`define PMC_INT_WAKE 0
`define PMC_INT_RSTWAKE 1
`define PMC_INT_ABORT 2
`define PMC_INT_CTW 3

// ****************************************************************
// Timing
// ****************************************************************
`define PMC_CLK_NS 20
`define PMC_SLEEP_WAKE_NS 15000
`define PMC_SLEEP_WAKE_CYC (`PMC_SLEEP_WAKE_NS / `PMC_CLK_NS)
`define PMC_HIB_WAKE_NS 100000
`define PMC_HIB_WAKE_CYC (`PMC_HIB_WAKE_NS / `PMC_CLK_NS - 1)
`define PMC_ENTRY_CYC 3'h4
`define PMC_RS_W 13

`endif

/* src/pmc_pkg.sv */
// Types shared by the power mode controller files.
// Assumes nothing beyond a SystemVerilog compiler.
package pmc_pkg;
  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'b00,
    MODE_ALT = 2'b01,
    MODE_SLEEP = 2'b10,
    MODE_HIB = 2'b11
  } mode_t;
  typedef enum logic [2:0] {
    ST_ACT = 3'b000,
    ST_ALT = 3'b001,
    ST_ENTER = 3'b010,
    ST_SLEEP = 3'b011,
    ST_HIB = 3'b100,
    ST_RESUME = 3'b101
  } state_t;
endpackage

/* src/power_mode_controller.sv */
// Global power mode controller with an AXI4-Lite register port.
// Assumes wake and reset event inputs are synchronous to clk.
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`include "pmc_params.svh"
module power_mode_controller
  import pmc_pkg::*;
#(
  parameter int NRES = `PMC_NRES,
  parameter int HIB_WAKE_CYC = `PMC_HIB_WAKE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`PMC_AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`PMC_AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [`PMC_NWAKE-1:0] wake_src,
  input wire logic external_reset_pin,
  input wire logic watchdog_reset_source,
  input wire logic precision_reset,
  output mode_t power_mode,
  output logic [NRES-1:0] res_clk_en,
  output logic [NRES-1:0] res_bias_en,
  output logic clk_run,
  output logic pin_hold,
  output logic irq
);
  localparam int RS_W = `PMC_RS_W;
  localparam int SLP_LEN = `PMC_SLEEP_WAKE_CYC - 1;
  localparam int HIB_LEN = HIB_WAKE_CYC - 1;

  if (NRES < 1 || NRES > 32 || HIB_WAKE_CYC < 2 ||
      HIB_WAKE_CYC >= (1 << RS_W)) begin : g_chk
    $error("power_mode_controller parameter out of range");
  end

  // ****************************************************************
  // AXI4-Lite channels
  // ****************************************************************
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic aw_have_r, w_have_r;
  logic [`PMC_AXI_AW-1:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r, wmask, cur_w, wval;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic wr_fire, wr_hit, rd_hit;
  logic [31:0] rd_word;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_r <= 1'b1;
      aw_have_r <= 1'b0;
      awaddr_r <= '0;
    end else if (awvalid && awready_r) begin
      awaddr_r <= awaddr;
      aw_have_r <= 1'b1;
      awready_r <= 1'b0;
    end else if (bvalid_r && bready) begin
      aw_have_r <= 1'b0;
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wready_r <= 1'b1;
      w_have_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (wvalid && wready_r) begin
      wdata_r <= wdata;
      wstrb_r <= wstrb;
      w_have_r <= 1'b1;
      wready_r <= 1'b0;
    end else if (bvalid_r && bready) begin
      w_have_r <= 1'b0;
      wready_r <= 1'b1;
    end
  end

  assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
  assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                  {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r <= `PMC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `PMC_RESP_OKAY;
    end else if (arvalid && arready_r) begin
      rdata_r <= rd_hit ? rd_word : 32'h0000_0000;
      rresp_r <= rd_hit ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
      rvalid_r <= 1'b1;
      arready_r <= 1'b0;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  state_t state_r, state_nxt;
  mode_t mode_r, mode_nxt;
  logic [NRES-1:0] act_tmpl_r, alt_tmpl_r;
  logic [`PMC_NWAKE-1:0] wake_en_r, last_wake_r;
  logic [`PMC_CTW_W-1:0] ctw_period_r;
  logic [`PMC_NINT-1:0] int_stat_r, int_mask_r, int_set;

  function automatic logic [32:0] reg_word(
    input logic [`PMC_AXI_AW-1:0] a);
    logic [31:0] v;
    logic hit;
    v = '0;
    hit = 1'b1;
    case (a)
      `PMC_OFF_MODE: begin
        v[1:0] = mode_r;
        v[`PMC_MODE_BUSY_BIT] = state_r == ST_ENTER ||
                                state_r == ST_RESUME;
        v[`PMC_MODE_LAST_LSB +: `PMC_NWAKE] = last_wake_r;
      end
      `PMC_OFF_ACT_TMPL: v[NRES-1:0] = act_tmpl_r;
      `PMC_OFF_ALT_TMPL: v[NRES-1:0] = alt_tmpl_r;
      `PMC_OFF_WAKE_EN: v[`PMC_NWAKE-1:0] = wake_en_r;
      `PMC_OFF_CTW_PERIOD: v[`PMC_CTW_W-1:0] = ctw_period_r;
      `PMC_OFF_INT_STAT: v[`PMC_NINT-1:0] = int_stat_r;
      `PMC_OFF_INT_MASK: v[`PMC_NINT-1:0] = int_mask_r;
      default: hit = 1'b0;
    endcase
    return {hit, v};
  endfunction

  // The lookup reads register state inside a function. A continuous
  // assignment would only wake on the address, so a repeated read of one
  // address would return a stale word.
  always_comb begin
    {rd_hit, rd_word} = reg_word(araddr);
  end

  always_comb begin
    {wr_hit, cur_w} = reg_word(awaddr_r);
  end
  assign wval = (cur_w & ~wmask) | (wdata_r & wmask);

  function automatic logic wr_to(input logic [`PMC_AXI_AW-1:0] off);
    return wr_fire && awaddr_r == off;
  endfunction

  // ****************************************************************
  // Wake sources
  // ****************************************************************
  logic ctw_tick, ctw_busy, rs_done;
  logic [`PMC_NWAKE-1:0] src, en_src;
  logic rst_any, wake_run, wake_slp, wake_hib, wake_now, rst_now;
  logic [2:0] enter_cnt_r;
  mode_t target_r;
  logic req_v, ctw_wr;

  assign src = wake_src | (`PMC_NWAKE'(ctw_tick) << `PMC_WK_CTW);
  assign en_src = src & wake_en_r;
  assign rst_any = external_reset_pin || watchdog_reset_source ||
                   precision_reset;
  assign wake_run = |en_src || rst_any;
  assign wake_slp = |(en_src & `PMC_SLEEP_WAKE_MASK) || rst_any;
  assign wake_hib = |(en_src & `PMC_HIB_WAKE_MASK) ||
                    external_reset_pin;

  always_comb begin
    wake_now = 1'b0;
    rst_now = 1'b0;
    case (state_r)
      ST_ACT, ST_ALT, ST_ENTER: begin
        wake_now = wake_run;
        rst_now = rst_any;
      end
      ST_SLEEP: begin
        wake_now = wake_slp;
        rst_now = rst_any;
      end
      ST_HIB: begin
        wake_now = wake_hib;
        rst_now = external_reset_pin;
      end
      default: ;
    endcase
  end

  // Decoded in the open here, since a constant function argument would
  // leave a continuous assignment with nothing to wake it.
  assign req_v = wr_fire && awaddr_r == `PMC_OFF_MODE && wstrb_r[0];
  assign ctw_wr = wr_fire && awaddr_r == `PMC_OFF_CTW_PERIOD;

  // ****************************************************************
  // Mode sequencer
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    case (state_r)
      ST_ACT, ST_ALT: begin
        if (wake_now) begin
          state_nxt = ST_ACT;
        end else if (req_v) begin
          case (mode_t'(wdata_r[1:0]))
            MODE_ACTIVE: state_nxt = ST_ACT;
            MODE_ALT: state_nxt = ST_ALT;
            default: state_nxt = ST_ENTER;
          endcase
        end
      end
      ST_ENTER: begin
        if (wake_now) begin
          state_nxt = ST_ACT;
        end else if (enter_cnt_r == 3'h1) begin
          state_nxt = target_r == MODE_HIB ? ST_HIB : ST_SLEEP;
        end
      end
      ST_SLEEP, ST_HIB: begin
        if (wake_now) begin
          state_nxt = ST_RESUME;
        end
      end
      ST_RESUME: begin
        if (rs_done) begin
          state_nxt = ST_ACT;
        end
      end
      default: state_nxt = ST_ACT;
    endcase
    case (state_nxt)
      ST_ACT: mode_nxt = MODE_ACTIVE;
      ST_ALT: mode_nxt = MODE_ALT;
      ST_SLEEP: mode_nxt = MODE_SLEEP;
      ST_HIB: mode_nxt = MODE_HIB;
      default: mode_nxt = mode_r;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_ACT;
      mode_r <= MODE_ACTIVE;
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
    end
  end

  // Entry takes a few cycles so a late wake can still cancel it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enter_cnt_r <= '0;
      target_r <= MODE_SLEEP;
    end else if (state_r != ST_ENTER && state_nxt == ST_ENTER) begin
      enter_cnt_r <= `PMC_ENTRY_CYC;
      target_r <= mode_t'(wdata_r[1:0]);
    end else if (enter_cnt_r != 3'h0) begin
      enter_cnt_r <= enter_cnt_r - 3'h1;
    end
  end

  cycle_timer #(.W(RS_W)) u_resume (
    .clk(clk),
    .rst_n(rst_n),
    .start(state_nxt == ST_RESUME && state_r != ST_RESUME),
    .clear(1'b0),
    .hold(1'b0),
    .periodic(1'b0),
    .len(state_r == ST_HIB ? RS_W'(HIB_LEN) : RS_W'(SLP_LEN)),
    .done_r(rs_done),
    .busy_r()
  );

  // The timewheel stands still in hibernate because no clocks run there.
  cycle_timer #(.W(`PMC_CTW_W)) u_timewheel (
    .clk(clk),
    .rst_n(rst_n),
    .start(!ctw_busy && ctw_period_r != '0),
    .clear(ctw_period_r == '0 || ctw_wr),
    .hold(state_r == ST_HIB),
    .periodic(1'b1),
    .len(ctw_period_r),
    .done_r(ctw_tick),
    .busy_r(ctw_busy)
  );

  // ****************************************************************
  // Templates and software registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_tmpl_r <= NRES'(`PMC_ACT_TMPL_RST);
    end else begin
      if (wr_to(`PMC_OFF_ACT_TMPL)) begin
        act_tmpl_r <= wval[NRES-1:0];
      end
      if (wake_now) begin
        act_tmpl_r[`PMC_RES_CPU] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alt_tmpl_r <= NRES'(`PMC_ALT_TMPL_RST);
      wake_en_r <= `PMC_WAKE_EN_RST;
      ctw_period_r <= '0;
      int_mask_r <= '0;
    end else begin
      if (wr_to(`PMC_OFF_ALT_TMPL)) alt_tmpl_r <= wval[NRES-1:0];
      if (wr_to(`PMC_OFF_WAKE_EN)) wake_en_r <= wval[`PMC_NWAKE-1:0];
      if (wr_to(`PMC_OFF_CTW_PERIOD)) begin
        ctw_period_r <= wval[`PMC_CTW_W-1:0];
      end
      if (wr_to(`PMC_OFF_INT_MASK)) int_mask_r <= wval[`PMC_NINT-1:0];
    end
  end

  always_comb begin
    int_set = '0;
    int_set[`PMC_INT_WAKE] = wake_now && state_r != ST_ACT;
    int_set[`PMC_INT_RSTWAKE] = rst_now;
    int_set[`PMC_INT_ABORT] = wake_now && state_r == ST_ENTER;
    int_set[`PMC_INT_CTW] = ctw_tick;
  end

  // A status event in the same cycle as its clear keeps the bit set.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat_r <= '0;
      last_wake_r <= '0;
    end else begin
      int_stat_r <= (int_stat_r & ~({`PMC_NINT{wr_to(`PMC_OFF_INT_STAT)}}
                    & wdata_r[`PMC_NINT-1:0] & wmask[`PMC_NINT-1:0]))
                    | int_set;
      if (wake_now && state_r != ST_ACT) last_wake_r <= en_src;
    end
  end

  // ****************************************************************
  // Power gating outputs
  // ****************************************************************
  logic [NRES-1:0] res_want_r, res_want;
  logic clk_run_r, pin_hold_r, irq_r;

  always_comb begin
    case (state_r)
      ST_SLEEP: res_want = NRES'(`PMC_SLEEP_KEEP);
      ST_HIB, ST_RESUME: res_want = '0;
      default: res_want = mode_r == MODE_ALT ? alt_tmpl_r
                                             : act_tmpl_r;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_want_r <= '0;
      clk_run_r <= 1'b1;
      pin_hold_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      res_want_r <= res_want;
      clk_run_r <= state_nxt != ST_HIB;
      pin_hold_r <= state_nxt == ST_HIB;
      irq_r <= |(int_stat_r & int_mask_r);
    end
  end

  for (genvar i = 0; i < NRES; i++) begin : g_gate
    resource_gate u_gate (
      .clk(clk),
      .rst_n(rst_n),
      .want(res_want_r[i]),
      .clk_en_r(res_clk_en[i]),
      .bias_en_r(res_bias_en[i])
    );
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign power_mode = mode_r;
  assign clk_run = clk_run_r;
  assign pin_hold = pin_hold_r;
  assign irq = irq_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_alt_wake_act: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == ST_ALT && wake_run |=> mode_r == MODE_ACTIVE)
    else $error("wake in alternate mode did not restore active");
  a_cpu_reenable: assert property (@(posedge clk) disable iff (!rst_n)
    wake_now |=> act_tmpl_r[`PMC_RES_CPU])
    else $error("wake did not re-enable the cpu");
  a_sleep_gating: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == ST_SLEEP |=> res_want_r == NRES'(`PMC_SLEEP_KEEP))
    else $error("sleep did not gate resources");
  a_hib_clk_stop: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == ST_HIB |-> !clk_run_r && pin_hold_r)
    else $error("hibernate left clocks running");
  a_hib_pin_hold: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pin_hold_r) |-> mode_r == MODE_HIB)
    else $error("pins held outside hibernate");
  a_sleep_resume: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == ST_RESUME && $past(state_r) == ST_SLEEP
    |-> ##[1:750] state_r == ST_ACT)
    else $error("sleep resume too slow");
  a_hib_pin_only: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == ST_HIB && !(|(src & wake_en_r & `PMC_HIB_WAKE_MASK))
    && !external_reset_pin |=> state_r == ST_HIB)
    else $error("hibernate left without pin wake");
  a_entry_abort: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == ST_ENTER && wake_run |=> state_r == ST_ACT)
    else $error("wake did not abandon entry");
  a_sleep_by_write: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(state_r == ST_SLEEP) |-> $past(state_r) == ST_ENTER)
    else $error("sleep entered without a request");
endmodule // power_mode_controller

/* src/resource_gate.sv */
// Power gate for one resource: analog bias and digital clock enable.
// Assumes the wanted state is a registered level from the controller.
`timescale 1ns/100ps
module resource_gate (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic want,
  output logic clk_en_r,
  output logic bias_en_r
);
  // Bias comes up a cycle before the clock and drops a cycle after it,
  // so a resource never runs clocked without its bias.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_en_r <= 1'b0;
      bias_en_r <= 1'b0;
    end else begin
      clk_en_r <= want && bias_en_r;
      bias_en_r <= want || clk_en_r;
    end
  end

  a_clk_needs_bias: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en_r |-> bias_en_r)
    else $error("resource clocked without bias");
endmodule // resource_gate

/* tb/testbench.sv */
// Self-checking bench: AXI4-Lite tasks and mode sequences.
// Assumes wake_model drives every event input of the controller.
`timescale 1ns/100ps
`include "pmc_params.svh"
module testbench
  import pmc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [1:0] bresp, rresp, rsp;
  logic awready, wready, bvalid, arready, rvalid;
  logic clk_run, pin_hold, irq, ext_pin, wd_src, pr_src;
  logic [9:0] req = 10'h000;
  logic [6:0] wake_src;
  logic [7:0] res_clk_en, res_bias_en;
  mode_t power_mode;
  int n_mismatch = 0, checks_done = 0, cyc = 0, n;

  always #10 clk = ~clk;

  power_mode_controller #(.HIB_WAKE_CYC(20)) i_power_mode_controller (
    .clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .wake_src(wake_src), .external_reset_pin(ext_pin),
    .watchdog_reset_source(wd_src), .precision_reset(pr_src),
    .power_mode(power_mode), .res_clk_en(res_clk_en),
    .res_bias_en(res_bias_en), .clk_run(clk_run),
    .pin_hold(pin_hold), .irq(irq));

  wake_model i_wake_model (.clk(clk), .rst_n(rst_n), .req(req),
    .wake_src(wake_src), .external_reset_pin(ext_pin),
    .watchdog_reset_source(wd_src), .precision_reset(pr_src));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic complete_run;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic ev(input logic [9:0] e);
    @(posedge clk);
    req <= e;
    @(posedge clk);
    req <= 10'h000;
  endtask

  task automatic wait_mode(input mode_t m);
    n = 0;
    while (power_mode !== m && n < 6000) begin
      @(posedge clk);
      n++;
    end
  endtask

  // A hang anywhere ends the run as a failure.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // ****************************************************************
  // Sequences
  // ****************************************************************
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(32'(power_mode), 32'(MODE_ACTIVE));
    chk(32'(res_clk_en), 32'h0000_00ff);
    rd(8'h1c);
    chk(32'(rsp), 32'(`PMC_RESP_SLVERR));
    wr(8'h1c, 32'h1);
    chk(32'(rsp), 32'(`PMC_RESP_SLVERR));
    wr(`PMC_OFF_ACT_TMPL, 32'h0000_00f0);
    chk(32'(rsp), 32'(`PMC_RESP_OKAY));
    repeat (4) @(posedge clk);
    chk(32'({res_clk_en, res_bias_en}), 32'h0000_f0f0);
    ev(10'h001);
    rd(`PMC_OFF_ACT_TMPL);
    chk(v, 32'h0000_00f1);
    wr(`PMC_OFF_MODE, 32'h1);
    wait_mode(MODE_ALT);
    repeat (4) @(posedge clk);
    chk(32'(res_clk_en), 32'h0000_00fe);
    ev(10'h020);
    wait_mode(MODE_ACTIVE);
    chk(32'(power_mode), 32'(MODE_ACTIVE));
    wr(`PMC_OFF_INT_MASK, 32'h1);
    for (int i = 0; i < 10; i++) begin
      if (i == 6) continue;
      wr(`PMC_OFF_MODE, 32'h2);
      wait_mode(MODE_SLEEP);
      ev(10'h040);
      repeat (4) @(posedge clk);
      chk(32'({power_mode, res_clk_en}), 32'({MODE_SLEEP, 8'h06}));
      ev(10'(1 << i));
      wait_mode(MODE_ACTIVE);
      // Three edges of model and sampling delay precede the count.
      chk(32'(n <= 750 + 3), 32'h1);
      chk(32'(irq), 32'h1);
      wr(`PMC_OFF_INT_STAT, 32'hf);
    end
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0);
    wr(`PMC_OFF_WAKE_EN, 32'h7e);
    wr(`PMC_OFF_MODE, 32'h2);
    wait_mode(MODE_SLEEP);
    ev(10'h001);
    repeat (4) @(posedge clk);
    chk(32'(power_mode), 32'(MODE_SLEEP));
    ev(10'h004);
    wait_mode(MODE_ACTIVE);
    chk(32'(power_mode), 32'(MODE_ACTIVE));
    wr(`PMC_OFF_WAKE_EN, 32'h7f);
    wr(`PMC_OFF_MODE, 32'h3);
    wait_mode(MODE_HIB);
    repeat (2) @(posedge clk);
    chk(32'({clk_run, pin_hold}), 32'h1);
    ev(10'h308);
    repeat (8) @(posedge clk);
    chk(32'(power_mode), 32'(MODE_HIB));
    ev(10'h002);
    wait_mode(MODE_ACTIVE);
    chk(32'(n <= 20 + 3), 32'h1);
    chk(32'({clk_run, pin_hold}), 32'h2);
    rd(`PMC_OFF_MODE);
    chk(v, 32'h0000_0200);
    wr(`PMC_OFF_INT_STAT, 32'hf);
    wr(`PMC_OFF_MODE, 32'h2);
    ev(10'h001);
    repeat (6) @(posedge clk);
    rd(`PMC_OFF_INT_STAT);
    chk(32'({power_mode, v[2]}), 32'h1);
    wr(`PMC_OFF_INT_STAT, 32'hf);
    wr(`PMC_OFF_CTW_PERIOD, 32'h200);
    wr(`PMC_OFF_MODE, 32'h2);
    wait_mode(MODE_SLEEP);
    wait_mode(MODE_ACTIVE);
    rd(`PMC_OFF_INT_STAT);
    chk(32'({power_mode, v[3]}), 32'h1);
    wr(`PMC_OFF_CTW_PERIOD, 32'h0);
    complete_run();
  end
endmodule // testbench

/* tb/wake_model.sv */
// Model of the wake and reset-wake sources outside the controller.
// Assumes the bench asks for events on req, synchronous to clk.
`timescale 1ns/100ps
module wake_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [9:0] req,
  output logic [6:0] wake_src,
  output logic external_reset_pin,
  output logic watchdog_reset_source,
  output logic precision_reset
);
  // ****************************************************************
  // Event drive
  // ****************************************************************
  // Each event is a one-cycle pulse with long gaps, so pins never
  // toggle fast while the device hibernates.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {precision_reset, watchdog_reset_source, external_reset_pin,
        wake_src} <= 10'h000;
    end else begin
      {precision_reset, watchdog_reset_source, external_reset_pin,
        wake_src} <= req;
    end
  end
endmodule // wake_model
